// ===== core/crs_core.sv
// crs_core: core special registers with their reset-class and wake-up behaviour.
// assumes all inputs except the asynchronous rst synchronous to clk; event inputs are one-cycle pulses.
// Behaviour
// RULE1: interrupt wake with enable loads vector
// RULE2: interrupt wake copies counter to stack top
// RULE3: interrupt wake advances return stack pointer
// RULE4: wake sets cause flag, others kept
// RULE5: unimplemented bits always read zero
// RULE6: port bits 6,7 only when oscillator frees; the direction flops leave reset at ff and are masked one edge later
// RULE7: watchdog wake leaves registers untouched
// RULE8: three classes with own reset values
// RULE9: undefined registers kept by later resets
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module crs_core (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire crs_pkg::crs_bus_req_t bus,
	output logic [7:0] rdata,
	// reset classes and wake events
	input wire crs_pkg::crs_evt_t ev,
	// oscillator mode and port pins
	input wire logic osc_frees_pins,
	input wire logic [7:0] port_pins_in,
	output logic [7:0] port_latch,
	output logic [7:0] port_dir,
	// core state
	output logic [20:0] pc,
	output logic irq
);
	import crs_pkg::*;

	crs_state_t q;
	crs_state_t d;

	// next-state logic: bus access first, then events so that hardware sets win
	always_comb begin
		logic [4:0] sp;
		logic [7:0] ev_bits;
		logic gie;
		d = q;
		sp = q.r[CRS_STK_PTR][4:0];
		ev_bits = 8'h00;
		gie = q.r[CRS_ICTL_MAIN][CRS_GIE_HIGH_BIT] | q.r[CRS_ICTL_MAIN][CRS_GIE_LOW_BIT];
		d.rdata = 8'h00;

		// register writes; the event status is write-one-to-clear
		if (bus.wr && bus.addr < 5'(CRS_NREG)) begin
			case (bus.addr)
				CRS_EVT_STAT: begin
					d.r[CRS_EVT_STAT] = q.r[CRS_EVT_STAT] & ~bus.wdata;
				end
				CRS_PC_LOW: begin
					d.pc = {q.r[CRS_PCLAT_U][4:0], q.r[CRS_PCLAT_H], bus.wdata};
				end
				CRS_PORT_DATA: begin
					d.r[CRS_PORT_LAT] = bus.wdata;
				end
				default: begin
					d.r[bus.addr] = bus.wdata;
				end
			endcase
		end

		// RULE8 class values
		if (ev.por || ev.master_clear) begin
			for (int i = 0; i < CRS_NREG; i++) begin
				// RULE9 undefined kept
				d.r[i] = (q.r[i] & CRS_KEEP[i]) | (CRS_RST_VAL[i] & ~CRS_KEEP[i]);
			end
			d.pc = CRS_PC_RESET;
			ev_bits[ev.por ? CRS_EV_POR : CRS_EV_MASTER_CLEAR] = 1'b1;
		end else if (ev.irq_wake || ev.wdt_wake) begin
			// RULE4 cause flag set
			case (ev.flag_sel)
				CRS_FSEL_MAIN: d.r[CRS_ICTL_MAIN] = d.r[CRS_ICTL_MAIN] | ev.flag_bits;
				CRS_FSEL_THIRD: d.r[CRS_ICTL_THIRD] = d.r[CRS_ICTL_THIRD] | ev.flag_bits;
				default: d.r[CRS_PERIPH_FLAG] = d.r[CRS_PERIPH_FLAG] | ev.flag_bits;
			endcase
			// RULE7 watchdog resumes
			d.pc = 21'(q.pc + CRS_PC_STEP);
			if (ev.irq_wake) begin
				ev_bits[CRS_EV_IRQ_WAKE] = 1'b1;
			end else begin
				ev_bits[CRS_EV_WDT_WAKE] = 1'b1;
			end
			if (ev.irq_wake && gie) begin
				// RULE1 vector load
				d.pc = ev.irq_high ? CRS_VEC_HIGH : CRS_VEC_LOW;
				// RULE2 stack top copy
				d.r[CRS_STK_TOP_U] = {3'h0, q.pc[20:16]};
				d.r[CRS_STK_TOP_H] = q.pc[15:8];
				d.r[CRS_STK_TOP_L] = q.pc[7:0];
				// RULE3 pointer advance; a full stack holds its pointer
				if (!q.r[CRS_STK_PTR][CRS_STK_FULL_BIT]) begin
					d.r[CRS_STK_PTR][4:0] = 5'(sp + 5'h01);
					if (5'(sp + 5'h01) == CRS_STK_LAST) begin
						d.r[CRS_STK_PTR][CRS_STK_FULL_BIT] = 1'b1;
						ev_bits[CRS_EV_STK_FULL] = 1'b1;
					end
				end else begin
					ev_bits[CRS_EV_STK_FULL] = 1'b1;
				end
			end
		end

		// the low counter byte mirrors the counter
		d.r[CRS_PC_LOW] = d.pc[7:0];
		// sticky event bits, set wins over a same-cycle clear
		d.r[CRS_EVT_STAT] = d.r[CRS_EVT_STAT] | ev_bits;

		// RULE5 unimplemented zero
		for (int i = 0; i < CRS_NREG; i++) begin
			// RULE6 port bits gated
			d.r[i] = d.r[i] & crs_mask(5'(i), osc_frees_pins);
		end

		// read data stand in the cycle after the strobe only
		if (bus.rd) begin
			if (bus.addr == CRS_PORT_DATA) begin
				d.rdata = port_pins_in & crs_mask(CRS_PORT_DATA, osc_frees_pins);
			end else if (bus.addr < 5'(CRS_NREG)) begin
				d.rdata = q.r[bus.addr] & crs_mask(bus.addr, osc_frees_pins);
			end
		end

		// level interrupt from the masked sticky bits
		d.irq = |(d.r[CRS_EVT_STAT] & d.r[CRS_EVT_MASK]);
	end

	// state register; asynchronous reset counts as power-on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= CRS_STATE_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state flops
	assign rdata = q.rdata;
	assign pc = q.pc;
	assign port_latch = q.r[CRS_PORT_LAT];
	assign port_dir = q.r[CRS_PORT_DIR];
	assign irq = q.irq;

	// helper terms for the checks below
	logic wake_push;
	logic plain_wdt;
	assign wake_push = ev.irq_wake && !ev.por && !ev.master_clear &&
		(q.r[CRS_ICTL_MAIN][CRS_GIE_HIGH_BIT] || q.r[CRS_ICTL_MAIN][CRS_GIE_LOW_BIT]);
	assign plain_wdt = ev.wdt_wake && !ev.irq_wake && !ev.por && !ev.master_clear && !bus.wr;

	// RULE1 vector check
	vector_load_a: assert property (@(posedge clk) disable iff (rst) // RULE1
		wake_push |=> pc == ($past(ev.irq_high) ? CRS_VEC_HIGH : CRS_VEC_LOW))
		else $error("counter not loaded with interrupt vector");

	// RULE2 stack top check
	stack_top_a: assert property (@(posedge clk) disable iff (rst) // RULE2
		wake_push |=> {q.r[CRS_STK_TOP_U][4:0], q.r[CRS_STK_TOP_H], q.r[CRS_STK_TOP_L]}
			== $past(q.pc))
		else $error("stack top does not hold the old counter");

	// RULE3 pointer check
	ptr_advance_a: assert property (@(posedge clk) disable iff (rst) // RULE3
		wake_push && !q.r[CRS_STK_PTR][CRS_STK_FULL_BIT]
		|=> q.r[CRS_STK_PTR][4:0] == 5'($past(q.r[CRS_STK_PTR][4:0]) + 5'h01))
		else $error("return stack pointer did not advance");

	// RULE4 flag check
	cause_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		(ev.irq_wake || ev.wdt_wake) && !ev.por && !ev.master_clear && !bus.wr
			&& ev.flag_sel == CRS_FSEL_MAIN
		|=> q.r[CRS_ICTL_MAIN] == ($past(q.r[CRS_ICTL_MAIN]) | $past(ev.flag_bits)))
		else $error("wake cause flag wrong or other bits disturbed");

	// RULE5 read check
	unimpl_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		bus.rd && bus.addr == CRS_STK_PTR ##1 bus.rd && bus.addr == CRS_IND0_H
		|-> ##1 rdata[7:4] == 4'h0 && $past(rdata[5]) == 1'b0)
		else $error("unimplemented bits read as one");

	// RULE6 port gate check; the direction flops leave reset at ff, masked one edge later
	port_gate_a: assert property (@(posedge clk) disable iff (rst) // RULE6
		!osc_frees_pins && !$past(rst)
		|=> port_latch[7:6] == 2'b00 && port_dir[7:6] == 2'b00)
		else $error("port bits 7:6 present with oscillator holding them");

	// RULE7 watchdog wake check
	wdt_resume_a: assert property (@(posedge clk) disable iff (rst) // RULE7
		plain_wdt |=> q.r[CRS_WORK] == $past(q.r[CRS_WORK])
			&& q.r[CRS_TBL_L] == $past(q.r[CRS_TBL_L])
			&& pc == 21'($past(q.pc) + CRS_PC_STEP))
		else $error("watchdog wake disturbed registers");

	// RULE8 class check
	class_reset_a: assert property (@(posedge clk) disable iff (rst) // RULE8
		ev.master_clear && !ev.por |=> q.r[CRS_ICTL_SECOND] == 8'hff
			&& q.r[CRS_ICTL_THIRD] == 8'hc0 && q.r[CRS_STK_PTR] == 8'h00 && pc == CRS_PC_RESET
			&& q.r[CRS_EVT_STAT][CRS_EV_MASTER_CLEAR])
		else $error("master-clear class values wrong");

	// RULE9 undefined keep check
	undef_keep_a: assert property (@(posedge clk) disable iff (rst) // RULE9
		(ev.master_clear || ev.por) |=> q.r[CRS_WORK] == $past(q.r[CRS_WORK])
			&& q.r[CRS_PROD_H] == $past(q.r[CRS_PROD_H])
			&& q.r[CRS_ICTL_MAIN][0] == $past(q.r[CRS_ICTL_MAIN][0]))
		else $error("undefined register changed by reset class");

	// interrupt output follows masked status
	irq_level_a: assert property (@(posedge clk) disable iff (rst)
		irq == |(q.r[CRS_EVT_STAT] & q.r[CRS_EVT_MASK]))
		else $error("interrupt output disagrees with status and mask");

	// RULE1 high vector
	vec_high_a: assert property (@(posedge clk) disable iff (rst) // RULE1
		wake_push && ev.irq_high |=> pc == CRS_VEC_HIGH)
		else $error("high priority vector not loaded");

	// RULE1 low vector
	vec_low_a: assert property (@(posedge clk) disable iff (rst) // RULE1
		wake_push && !ev.irq_high |=> pc == CRS_VEC_LOW)
		else $error("low priority vector not loaded");

	// RULE1 no enable steps
	no_gie_step_a: assert property (@(posedge clk) disable iff (rst) // RULE1
		ev.irq_wake && !ev.por && !ev.master_clear && !q.r[CRS_ICTL_MAIN][7] && !q.r[CRS_ICTL_MAIN][6]
		|=> pc == 21'($past(q.pc) + CRS_PC_STEP))
		else $error("disabled interrupt wake did not step the counter");

	// RULE3 no enable, no push
	no_gie_push_a: assert property (@(posedge clk) disable iff (rst) // RULE3
		ev.irq_wake && !ev.por && !ev.master_clear && !bus.wr
			&& !q.r[CRS_ICTL_MAIN][7] && !q.r[CRS_ICTL_MAIN][6]
		|=> q.r[CRS_STK_PTR] == $past(q.r[CRS_STK_PTR]))
		else $error("disabled interrupt wake moved the pointer");

	// RULE3 full stack holds
	stack_full_a: assert property (@(posedge clk) disable iff (rst) // RULE3
		wake_push && !bus.wr && q.r[CRS_STK_PTR][CRS_STK_FULL_BIT]
		|=> q.r[CRS_STK_PTR] == $past(q.r[CRS_STK_PTR]) && q.r[CRS_EVT_STAT][CRS_EV_STK_FULL])
		else $error("push onto a full stack moved the pointer");

	// RULE3 reaching the last slot
	stack_fill_a: assert property (@(posedge clk) disable iff (rst) // RULE3
		wake_push && !bus.wr && q.r[CRS_STK_PTR] == 8'h1e
		|=> q.r[CRS_STK_PTR][CRS_STK_FULL_BIT] && q.r[CRS_EVT_STAT][CRS_EV_STK_FULL])
		else $error("full mark not raised at the last slot");

	// RULE4 third control flag
	cause_third_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		(ev.irq_wake || ev.wdt_wake) && !ev.por && !ev.master_clear && !bus.wr
			&& ev.flag_sel == CRS_FSEL_THIRD
		|=> q.r[CRS_ICTL_THIRD] == ($past(q.r[CRS_ICTL_THIRD]) | $past(ev.flag_bits)))
		else $error("third control cause flag wrong");

	// RULE4 peripheral flag
	cause_periph_a: assert property (@(posedge clk) disable iff (rst) // RULE4
		(ev.irq_wake || ev.wdt_wake) && !ev.por && !ev.master_clear && !bus.wr && ev.flag_sel[1]
		|=> q.r[CRS_PERIPH_FLAG] == ($past(q.r[CRS_PERIPH_FLAG]) | $past(ev.flag_bits)))
		else $error("peripheral cause flag wrong");

	// interrupt wake is recorded in the event status
	irq_wake_stat_a: assert property (@(posedge clk) disable iff (rst)
		ev.irq_wake && !ev.por && !ev.master_clear |=> q.r[CRS_EVT_STAT][CRS_EV_IRQ_WAKE])
		else $error("interrupt wake not recorded");

	// RULE5 stack top upper bits
	top_upper_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		q.r[CRS_STK_TOP_U][7:5] == 3'h0)
		else $error("stack top upper holds unimplemented bits");

	// RULE5 pointer bit five
	ptr_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		q.r[CRS_STK_PTR][5] == 1'b0)
		else $error("pointer holds unimplemented bit");

	// RULE5 table pointer upper
	tbl_upper_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		q.r[CRS_TBL_U][7:6] == 2'h0)
		else $error("table pointer upper holds unimplemented bits");

	// RULE5 indirect pointer high
	ind_high_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		q.r[CRS_IND0_H][7:4] == 4'h0)
		else $error("indirect pointer high holds unimplemented bits");

	// RULE5 unmapped index reads zero
	unmapped_rd_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		bus.rd && bus.addr >= 5'(CRS_NREG) |=> rdata == 8'h00)
		else $error("unmapped index read non-zero");

	// RULE5 read data only after a strobe
	idle_rdata_a: assert property (@(posedge clk) disable iff (rst) // RULE5
		!bus.rd |=> rdata == 8'h00)
		else $error("read data present without a read strobe");

	// RULE6 pin read gated
	port_read_a: assert property (@(posedge clk) disable iff (rst) // RULE6
		bus.rd && bus.addr == CRS_PORT_DATA && !osc_frees_pins |=> rdata[7:6] == 2'b00)
		else $error("port pins 7:6 read while oscillator holds them");

	// RULE6 free pins take writes
	port_free_a: assert property (@(posedge clk) disable iff (rst) // RULE6
		osc_frees_pins && bus.wr && bus.addr == CRS_PORT_LAT && !ev.por && !ev.master_clear
		|=> port_latch == $past(bus.wdata))
		else $error("free port latch did not take the write");

	// RULE7 stack untouched
	wdt_stack_a: assert property (@(posedge clk) disable iff (rst) // RULE7
		plain_wdt |=> q.r[CRS_STK_PTR] == $past(q.r[CRS_STK_PTR])
			&& q.r[CRS_STK_TOP_L] == $past(q.r[CRS_STK_TOP_L]))
		else $error("watchdog wake disturbed the stack");

	// RULE7 latches untouched
	wdt_latch_a: assert property (@(posedge clk) disable iff (rst) // RULE7
		plain_wdt |=> q.r[CRS_PCLAT_H] == $past(q.r[CRS_PCLAT_H])
			&& q.r[CRS_ICTL_SECOND] == $past(q.r[CRS_ICTL_SECOND]))
		else $error("watchdog wake disturbed latch or control");

	// RULE7 wake recorded
	wdt_status_a: assert property (@(posedge clk) disable iff (rst) // RULE7
		plain_wdt |=> q.r[CRS_EVT_STAT][CRS_EV_WDT_WAKE])
		else $error("watchdog wake not recorded");

	// RULE8 power-on class
	por_class_a: assert property (@(posedge clk) disable iff (rst) // RULE8
		ev.por |=> pc == CRS_PC_RESET && q.r[CRS_STK_PTR] == 8'h00
			&& q.r[CRS_TBL_LAT] == 8'h00 && q.r[CRS_EVT_STAT][CRS_EV_POR])
		else $error("power-on class values wrong");

	// RULE8 latches cleared
	class_latch_a: assert property (@(posedge clk) disable iff (rst) // RULE8
		ev.por || ev.master_clear |=> q.r[CRS_PCLAT_U] == 8'h00 && q.r[CRS_PCLAT_H] == 8'h00
			&& q.r[CRS_TBL_H] == 8'h00 && q.r[CRS_ICTL_MAIN][7:1] == 7'h00)
		else $error("class reset left latches or enables set");

	// RULE9 indirect kept
	undef_ind_a: assert property (@(posedge clk) disable iff (rst) // RULE9
		ev.por || ev.master_clear |=> q.r[CRS_IND0_H] == $past(q.r[CRS_IND0_H])
			&& q.r[CRS_IND0_L] == $past(q.r[CRS_IND0_L]))
		else $error("class reset changed the indirect pointer");

	// status clear by writing ones, when no event competes
	status_clear_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == CRS_EVT_STAT && !ev.por && !ev.master_clear && !ev.wdt_wake
			&& !ev.irq_wake
		|=> q.r[CRS_EVT_STAT] == ($past(q.r[CRS_EVT_STAT]) & ~$past(bus.wdata)))
		else $error("status clear wrong");

	// low counter byte reads as the counter
	pc_read_a: assert property (@(posedge clk) disable iff (rst)
		bus.rd && bus.addr == CRS_PC_LOW |=> rdata == $past(q.pc[7:0]))
		else $error("counter low byte read wrong");

	// writing the low byte loads the whole counter from the latches
	pc_load_a: assert property (@(posedge clk) disable iff (rst)
		bus.wr && bus.addr == CRS_PC_LOW && !ev.por && !ev.master_clear && !ev.wdt_wake && !ev.irq_wake
		|=> pc == {$past(q.r[CRS_PCLAT_U][4:0]), $past(q.r[CRS_PCLAT_H]), $past(bus.wdata)})
		else $error("counter not loaded from latches");

endmodule

// ===== core/crs_pkg.sv
// crs_pkg: constants and carrier types for the core register reset-state bank.
// assumes a single 100 MHz core clock and 8-bit register data.
package crs_pkg;

	localparam int CRS_NREG = 25;
	localparam int CRS_AW = 5;

	// register indices on the register port
	localparam logic [4:0] CRS_STK_TOP_U = 5'h00;
	localparam logic [4:0] CRS_STK_TOP_H = 5'h01;
	localparam logic [4:0] CRS_STK_TOP_L = 5'h02;
	localparam logic [4:0] CRS_STK_PTR = 5'h03;
	localparam logic [4:0] CRS_PCLAT_U = 5'h04;
	localparam logic [4:0] CRS_PCLAT_H = 5'h05;
	localparam logic [4:0] CRS_PC_LOW = 5'h06;
	localparam logic [4:0] CRS_TBL_U = 5'h07;
	localparam logic [4:0] CRS_TBL_H = 5'h08;
	localparam logic [4:0] CRS_TBL_L = 5'h09;
	localparam logic [4:0] CRS_TBL_LAT = 5'h0a;
	localparam logic [4:0] CRS_PROD_H = 5'h0b;
	localparam logic [4:0] CRS_PROD_L = 5'h0c;
	localparam logic [4:0] CRS_ICTL_MAIN = 5'h0d;
	localparam logic [4:0] CRS_ICTL_SECOND = 5'h0e;
	localparam logic [4:0] CRS_ICTL_THIRD = 5'h0f;
	localparam logic [4:0] CRS_IND0_H = 5'h10;
	localparam logic [4:0] CRS_IND0_L = 5'h11;
	localparam logic [4:0] CRS_WORK = 5'h12;
	localparam logic [4:0] CRS_PORT_DATA = 5'h13;
	localparam logic [4:0] CRS_PORT_LAT = 5'h14;
	localparam logic [4:0] CRS_PORT_DIR = 5'h15;
	localparam logic [4:0] CRS_PERIPH_FLAG = 5'h16;
	localparam logic [4:0] CRS_EVT_STAT = 5'h17;
	localparam logic [4:0] CRS_EVT_MASK = 5'h18;

	// field positions
	localparam int CRS_GIE_HIGH_BIT = 7;
	localparam int CRS_GIE_LOW_BIT = 6;
	localparam int CRS_STK_FULL_BIT = 7;
	localparam logic [4:0] CRS_STK_LAST = 5'h1f;
	localparam int CRS_EV_POR = 0;
	localparam int CRS_EV_MASTER_CLEAR = 1;
	localparam int CRS_EV_WDT_WAKE = 2;
	localparam int CRS_EV_IRQ_WAKE = 3;
	localparam int CRS_EV_STK_FULL = 4;
	localparam logic [7:0] CRS_PORT_FREE_BITS = 8'hc0;

	// program counter values
	localparam logic [20:0] CRS_PC_RESET = 21'h000000;
	localparam logic [20:0] CRS_VEC_HIGH = 21'h000008;
	localparam logic [20:0] CRS_VEC_LOW = 21'h000018;
	localparam logic [20:0] CRS_PC_STEP = 21'h000002;

	// wake flag destination select
	localparam logic [1:0] CRS_FSEL_MAIN = 2'h0;
	localparam logic [1:0] CRS_FSEL_THIRD = 2'h1;

	// per-register tables, highest index first
	localparam logic [CRS_NREG-1:0][7:0] CRS_RST_VAL = '{
		8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0,
		8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [CRS_NREG-1:0][7:0] CRS_IMPL = '{
		8'h1f, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
		8'h1f, 8'hdf, 8'hff, 8'hff, 8'h1f};
	localparam logic [CRS_NREG-1:0][7:0] CRS_KEEP = '{
		8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h0f, 8'h00,
		8'h00, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} crs_bus_req_t;

	typedef struct packed {
		logic por;
		logic master_clear;
		logic wdt_wake;
		logic irq_wake;
		logic irq_high;
		logic [1:0] flag_sel;
		logic [7:0] flag_bits;
	} crs_evt_t;

	typedef struct packed {
		logic [CRS_NREG-1:0][7:0] r;
		logic [20:0] pc;
		logic [7:0] rdata;
		logic irq;
	} crs_state_t;

	localparam crs_state_t CRS_STATE_RST = '{r: CRS_RST_VAL, pc: CRS_PC_RESET,
		rdata: 8'h00, irq: 1'b0};

	// implemented bits of a register, port bits 7:6 only while the oscillator frees them
	function automatic logic [7:0] crs_mask(input logic [4:0] idx, input logic osc_free);
		logic [7:0] m;
		m = CRS_IMPL[idx];
		if (!osc_free && (idx == CRS_PORT_DATA || idx == CRS_PORT_LAT || idx == CRS_PORT_DIR)) begin
			m = m & ~CRS_PORT_FREE_BITS;
		end
		return m;
	endfunction

endpackage

// ===== verif/crs_tb.sv
// crs_tb: self-checking bench for the core register reset-state bank.
// assumes crs_pkg and crs_core are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`define CHK(a, e) chk(32'(a), 32'(e))
module testbench;
	import crs_pkg::*;
	logic clk;
	logic rst;
	crs_bus_req_t bus;
	crs_evt_t ev;
	logic osc_free;
	logic [7:0] pins;
	logic [7:0] rdata;
	logic [7:0] lat;
	logic [7:0] dir;
	logic [20:0] pc;
	logic irq;
	int miscompares;
	int cmp_count;
	logic [7:0] q;

	crs_core i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .ev(ev),
		.osc_frees_pins(osc_free), .port_pins_in(pins), .port_latch(lat),
		.port_dir(dir), .pc(pc), .irq(irq));

	// four-state compare so an unknown never counts as a match
	task automatic chk(input logic [31:0] a, input logic [31:0] e);
		cmp_count++;
		if (a !== e) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, a, e);
		end
	endtask

	// one-cycle write strobe; idle cycle after keeps strobes from merging
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 q = rdata;
	endtask

	// kind is {por, master_clear, watchdog wake, interrupt wake}
	task automatic evp(input logic [3:0] k, input logic h, input logic [1:0] s,
		input logic [7:0] b);
		@(posedge clk);
		ev <= {k, h, s, b};
		@(posedge clk);
		ev <= '0;
		#1;
	endtask

	// values straight after power-on, plus an unmapped index
	task automatic t_reset();
		logic [4:0] idx [6] = '{5'h0e, 5'h0f, 5'h15, 5'h17, 5'h03, 5'h19};
		logic [7:0] exp [6] = '{8'hff, 8'hc0, 8'h3f, 8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			rd(idx[i]);
			`CHK(q, exp[i]); // class value
		end
		`CHK(dir, 8'h3f); // direction gated
		`CHK(irq, 1'b0); // no interrupt
		$display("test reset done");
	endtask

	// missing bits read zero; port top bits follow the oscillator mode
	task automatic t_bits();
		wr(CRS_STK_TOP_U, 8'hff);
		rd(CRS_STK_TOP_U);
		`CHK(q, 8'h1f); // five bits
		wr(CRS_TBL_U, 8'hff);
		rd(CRS_TBL_U);
		`CHK(q, 8'h3f); // six bits
		wr(CRS_IND0_H, 8'hff);
		@(posedge clk);
		bus <= '{addr: CRS_STK_PTR, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '{addr: CRS_IND0_H, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		#1 `CHK(rdata, 8'h00); // pointer read
		@(posedge clk);
		bus <= '0;
		#1 `CHK(rdata, 8'h0f); // four bits
		wr(CRS_PORT_LAT, 8'hff);
		`CHK(lat, 8'h3f); // pins taken
		rd(CRS_PORT_DATA);
		`CHK(q, 8'h3f); // pins taken
		@(posedge clk);
		osc_free <= 1'b1;
		wr(CRS_PORT_LAT, 8'hff);
		`CHK(lat, 8'hff); // pins free
		rd(CRS_PORT_DATA);
		`CHK(q, 8'hff); // pins free
		$display("test bits done");
	endtask

	// master clear restores defined registers and keeps undefined ones
	task automatic t_master_clear();
		wr(CRS_WORK, 8'ha5);
		wr(CRS_TBL_LAT, 8'h5a);
		wr(CRS_ICTL_SECOND, 8'h12);
		evp(4'b0100, 1'b0, 2'h0, 8'h00);
		`CHK(pc, CRS_PC_RESET); // counter cleared
		rd(CRS_WORK);
		`CHK(q, 8'ha5); // kept
		rd(CRS_TBL_LAT);
		`CHK(q, 8'h00); // latch cleared
		rd(CRS_ICTL_SECOND);
		`CHK(q, 8'hff); // control value
		rd(CRS_EVT_STAT);
		`CHK(q, 8'h03); // cause bits
		$display("test master_clear done");
	endtask

	// interrupt wakes at both priorities push the counter and vector
	task automatic t_irq();
		wr(CRS_ICTL_MAIN, 8'h80);
		wr(CRS_PCLAT_U, 8'h01);
		wr(CRS_PCLAT_H, 8'h23);
		wr(CRS_PC_LOW, 8'h44);
		`CHK(pc, 21'h012344); // counter source
		evp(4'b0001, 1'b1, CRS_FSEL_MAIN, 8'h04);
		`CHK(pc, CRS_VEC_HIGH); // high vector
		rd(CRS_STK_TOP_U);
		`CHK(q, 8'h01); // upper copy
		rd(CRS_STK_TOP_H);
		`CHK(q, 8'h23); // high copy
		rd(CRS_STK_TOP_L);
		`CHK(q, 8'h44); // low copy
		rd(CRS_STK_PTR);
		`CHK(q, 8'h01); // one push
		rd(CRS_ICTL_MAIN);
		`CHK(q, 8'h84); // flag ored
		wr(CRS_ICTL_MAIN, 8'h40);
		evp(4'b0001, 1'b0, CRS_FSEL_THIRD, 8'h01);
		`CHK(pc, CRS_VEC_LOW); // low vector
		rd(CRS_STK_TOP_L);
		`CHK(q, 8'h08); // old vector pushed
		rd(CRS_STK_PTR);
		`CHK(q, 8'h02); // second push
		rd(CRS_ICTL_THIRD);
		`CHK(q, 8'hc1); // others kept
		$display("test irq done");
	endtask

	// watchdog wake only steps the counter and flags; then mask and clear
	task automatic t_wdt();
		wr(CRS_TBL_LAT, 8'h3c);
		evp(4'b0010, 1'b0, 2'h2, 8'h10);
		`CHK(pc, CRS_VEC_LOW + CRS_PC_STEP); // counter plus two
		rd(CRS_TBL_LAT);
		`CHK(q, 8'h3c); // untouched
		rd(CRS_STK_PTR);
		`CHK(q, 8'h02); // no push
		rd(CRS_PERIPH_FLAG);
		`CHK(q, 8'h10); // peripheral flag
		`CHK(irq, 1'b0); // masked
		wr(CRS_EVT_MASK, 8'h04);
		rd(CRS_EVT_STAT);
		`CHK(q, 8'h0f); // wake recorded
		`CHK(irq, 1'b1); // unmasked
		wr(CRS_EVT_STAT, 8'h04);
		rd(CRS_EVT_STAT);
		`CHK(q, 8'h0b); // cleared
		`CHK(irq, 1'b0); // cleared
		wr(CRS_EVT_STAT, 8'hff);
		evp(4'b1000, 1'b0, 2'h0, 8'h00);
		`CHK(pc, CRS_PC_RESET); // power-on counter
		rd(CRS_EVT_STAT);
		`CHK(q, 8'h01); // power-on cause
		rd(CRS_STK_PTR);
		`CHK(q, 8'h00); // pointer cleared
		evp(4'b0001, 1'b1, CRS_FSEL_MAIN, 8'h02);
		`CHK(pc, CRS_PC_RESET + CRS_PC_STEP); // no enable steps
		rd(CRS_STK_PTR);
		`CHK(q, 8'h00); // no push
		rd(CRS_ICTL_MAIN);
		`CHK(q, 8'h02); // flag set
		$display("test wdt done");
	endtask

	// counts first, then the single verdict
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// main sequence
	initial begin
		rst = 1'b1;
		bus = '0;
		ev = '0;
		osc_free = 1'b0;
		pins = 8'hff;
		q = 8'h00;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_bits();
		t_master_clear();
		t_irq();
		t_wdt();
		end_of_test();
	end

	// the run takes about 120 cycles; this cuts a hang short
	initial begin
		#20000;
		miscompares++;
		end_of_test();
	end
endmodule
